/* File: rtl/sbg_fifo.sv */
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: one clock, synchronous reset copy from the top
// Notes:   full and empty are exact; no write when full, no read when empty
`default_nettype none

module sbg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + AW'(1);
      if (doRd) rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + AW'(1);
      if (doWr && !doRd) count <= count + (AW+1)'(1);
      else if (doRd && !doWr) count <= count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (doWr) mem[wrPtr] <= inData;
  end
endmodule // sbg_fifo
`default_nettype wire

/* File: rtl/sbg_pkg.sv */
// Purpose: constants for the baud generator and hold/irq control block
// Assumes: classic wishbone, 32-bit data, byte registers in the low lane
// Notes:   all offsets and field positions live here
//
// Overview of operation
// - baud generator reloads from the baud reload register; clocks both master modes
// - writing the serial buffer in a master mode starts the baud generator counting down
// - transfer done stops the generator; serial clock holds its last level
// - counter reloads twice per serial clock period
// - serial clock equals system clock over four times reload plus one
// - ack time flag sets on eighth scl fall when address or data hold is enabled, clears on ninth rise
// - stop interrupt enable lets a stop raise the serial event flag
// - start interrupt enable lets a start raise the serial event flag
// - spi slave overwrite on: byte replaces buffer even when full, overflow set
// - spi slave overwrite off: full buffer kept, overflow set; masters ignore bit
// - i2c slave: overwrite on loads when buffer empty; off loads when buffer empty and no overflow
// - sda hold select picks 300 ns or 100 ns hold after scl fall
// - address hold: after eighth fall of matching address clear release, hold scl
// - data hold: after eighth fall of data byte clear release, hold scl
`default_nettype none

package sbg_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [3:0] ADDR_CTRL3   = 4'h0;
  localparam logic [3:0] ADDR_RELOAD  = 4'h4;
  localparam logic [3:0] ADDR_BUFFER  = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hc;
  localparam logic [3:0] ADDR_MODE    = 4'h0; // unused alias guard
  // ==========================================================================
  // control three fields
  localparam int BIT_ACKTIME   = 7;
  localparam int BIT_STOPIE    = 6;
  localparam int BIT_STARTIE   = 5;
  localparam int BIT_OVERWRITE = 4;
  localparam int BIT_HOLDSEL   = 3;
  localparam int BIT_COLLDET   = 2;
  localparam int BIT_ADDRHOLD  = 1;
  localparam int BIT_DATAHOLD  = 0;
  localparam logic [7:0] CTRL3_RESET = 8'h00;
  localparam logic [7:0] CTRL3_WMASK = 8'h7f;
  // ==========================================================================
  // status register fields (write one to clear on event, collision and overflow flags)
  localparam int ST_EVENT    = 0;
  localparam int ST_COLL     = 1;
  localparam int ST_OVF      = 2;
  localparam int ST_FULL     = 3;
  localparam int ST_RELEASE  = 4;
  localparam int ST_BUSY     = 5;
  localparam int ST_MODE_LO  = 8;
  // ==========================================================================
  // modes
  typedef enum logic [1:0] {
    MODE_SPI_MASTER,
    MODE_SPI_SLAVE,
    MODE_I2C_MASTER,
    MODE_I2C_SLAVE
  } sbg_mode_t;
  // ==========================================================================
  // timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int HOLD_LONG_NS = 300;
  localparam int HOLD_SHORT_NS = 100;
  localparam int HOLD_LONG_CYC  = (HOLD_LONG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HOLD_SHORT_CYC = (HOLD_SHORT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BITS_PER_BYTE = 8;
  localparam int FIFO_DEPTH    = 32;
  localparam int FIFO_WIDTH    = 8;
endpackage : sbg_pkg

`default_nettype wire

/* File: rtl/sbg_top.sv */
// Purpose: baud generator, hold/irq control register and receive buffer policy
// Assumes: pins synchronous to clk; shifter and start/stop detect are outside
// Notes:   transmit bytes pass through a 32 word fifo before the shifter
`default_nettype none

module sbg_top (
  input  wire logic       clk,
  input  wire logic       rst_n,
  // wishbone classic slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [3:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // mode and shifter side
  input  wire logic [1:0] mode,
  input  wire logic       xferDone,
  output logic [7:0]      txByte,
  output logic            txValid,
  input  wire logic       txReady,
  input  wire logic       rxStrobe,
  input  wire logic       rxIsAddr,
  input  wire logic       rxAddrMatch,
  input  wire logic [7:0] rxByte,
  output logic            rxAck,
  input  wire logic       startSeen,
  input  wire logic       stopSeen,
  // i2c line observation and control
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  input  wire logic       sdaDrivingHigh,
  output logic            sclOut,
  output logic            sclHoldLow,
  output logic            sdaHoldDone,
  output logic            busIdle
);
  // ==========================================================================
  // reset release
  logic rstSync1;
  logic rstN;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstN     <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstN     <= rstSync1;
    end
  end

  // ==========================================================================
  // registers
  logic [7:0] ctrl3;
  logic [7:0] reload;
  logic [7:0] rxBuf;
  logic       evtFlag;
  logic       collFlag;
  logic       ovfFlag;
  logic       fullFlag;
  logic       releaseBit;
  logic       ackTime;
  logic       genRun;
  logic [8:0] baudCnt;
  logic [3:0] fallCnt;
  logic       sclPrev;
  logic [4:0] holdCnt;

  logic       isI2c;
  logic       isSlave;
  logic       wrAcc;
  logic       rdBuf;
  logic       sclFall;
  logic       sclRise;
  logic       fifoInReady;
  logic       bufWrite;
  logic       rxLoad;
  logic       rxOvf;
  logic       holdEvent;
  logic       collide;

  assign isI2c   = mode[1];
  assign isSlave = (mode == sbg_pkg::MODE_SPI_SLAVE) || (mode == sbg_pkg::MODE_I2C_SLAVE);
  assign sclFall = sclPrev && !sclIn;
  assign sclRise = !sclPrev && sclIn;

  // ==========================================================================
  // wishbone: one wait state; ack drops the cycle after it rises
  assign wrAcc    = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
  assign rdBuf    = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
                    && (wb_adr_i == sbg_pkg::ADDR_BUFFER);
  assign bufWrite = wrAcc && (wb_adr_i == sbg_pkg::ADDR_BUFFER);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      unique case (wb_adr_i)
        sbg_pkg::ADDR_CTRL3:  wb_dat_o <= {24'h000000, ctrl3};
        sbg_pkg::ADDR_RELOAD: wb_dat_o <= {24'h000000, reload};
        sbg_pkg::ADDR_BUFFER: wb_dat_o <= {24'h000000, rxBuf};
        sbg_pkg::ADDR_STATUS: wb_dat_o <= {22'h0, mode, 2'h0, genRun, releaseBit,
                                           fullFlag, ovfFlag, collFlag, evtFlag};
        default:              wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // control three
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctrl3 <= sbg_pkg::CTRL3_RESET;
    end else begin
      if (wrAcc && wb_adr_i == sbg_pkg::ADDR_CTRL3)
        ctrl3 <= (ctrl3 & ~sbg_pkg::CTRL3_WMASK)
                 | (wb_dat_i[7:0] & sbg_pkg::CTRL3_WMASK);
      ctrl3[sbg_pkg::BIT_ACKTIME] <= ackTime;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) reload <= 8'h00;
    else if (wrAcc && wb_adr_i == sbg_pkg::ADDR_RELOAD) reload <= wb_dat_i[7:0];
  end

  // ==========================================================================
  // baud generator: reload twice per period -> f = clk / (4*(reload+1))
  // each half period is 2*(reload+1) clocks, counted down from 2*reload+1
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      genRun  <= 1'b0;
      baudCnt <= 9'h000;
      sclOut  <= 1'b1;
    end else begin
      if (bufWrite && !isSlave) begin
        genRun  <= 1'b1;
        baudCnt <= {reload, 1'b1};
      end else if (xferDone) begin
        genRun <= 1'b0; // sclOut keeps its level
      end else if (genRun && !(isI2c && sclHoldLow)) begin
        if (baudCnt == 9'h000) begin
          baudCnt <= {reload, 1'b1};
          sclOut  <= !sclOut;
        end else begin
          baudCnt <= baudCnt - 9'h001;
        end
      end
    end
  end

  // ==========================================================================
  // transmit fifo: bus writes are acked at once; a write to a full fifo is dropped
  sbg_fifo #(.WIDTH(sbg_pkg::FIFO_WIDTH), .DEPTH(sbg_pkg::FIFO_DEPTH)) txFifo (
    .clk      (clk),
    .rstN     (rstN),
    .inData   (wb_dat_i[7:0]),
    .inValid  (bufWrite),
    .inReady  (fifoInReady),
    .outData  (txByte),
    .outValid (txValid),
    .outReady (txReady)
  );

  // ==========================================================================
  // receive buffer policy
  always_comb begin
    rxLoad = 1'b0;
    rxOvf  = 1'b0;
    if (rxStrobe && isSlave && (!rxIsAddr || rxAddrMatch || !isI2c)) begin
      if (!isI2c) begin
        rxOvf  = fullFlag;
        rxLoad = !fullFlag || ctrl3[sbg_pkg::BIT_OVERWRITE];
      end else if (ctrl3[sbg_pkg::BIT_OVERWRITE]) begin
        rxLoad = !fullFlag;
        rxOvf  = fullFlag;
      end else begin
        rxLoad = !ovfFlag && !fullFlag;
        rxOvf  = fullFlag;
      end
    end else if (rxStrobe) begin
      rxLoad = !isSlave; // masters ignore the overwrite bit
    end
  end
  assign rxAck = rxLoad && isI2c;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxBuf    <= 8'h00;
      fullFlag <= 1'b0;
      ovfFlag  <= 1'b0;
    end else begin
      if (rxLoad) rxBuf <= rxByte;
      // set wins over clear
      if (rxLoad) fullFlag <= 1'b1;
      else if (rdBuf) fullFlag <= 1'b0;
      if (rxOvf) ovfFlag <= 1'b1;
      else if (wrAcc && wb_adr_i == sbg_pkg::ADDR_STATUS && wb_dat_i[sbg_pkg::ST_OVF])
        ovfFlag <= 1'b0;
    end
  end

  // ==========================================================================
  // ack time, holds, events, collision
  assign holdEvent = isI2c && isSlave && sclFall && fallCnt == 4'd7
                     && ((rxIsAddr && rxAddrMatch && ctrl3[sbg_pkg::BIT_ADDRHOLD])
                         || (!rxIsAddr && ctrl3[sbg_pkg::BIT_DATAHOLD]));
  assign collide   = isI2c && isSlave && ctrl3[sbg_pkg::BIT_COLLDET]
                     && sclRise && !sdaIn && sdaDrivingHigh;
  assign sclHoldLow = !releaseBit;
  assign busIdle    = !genRun && (fallCnt == 4'd0);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sclPrev    <= 1'b1;
      fallCnt    <= 4'd0;
      ackTime    <= 1'b0;
      releaseBit <= 1'b1;
      collFlag   <= 1'b0;
      evtFlag    <= 1'b0;
    end else begin
      sclPrev <= sclIn;
      if (startSeen || stopSeen || collide) fallCnt <= 4'd0;
      else if (sclFall) fallCnt <= (fallCnt == 4'd8) ? 4'd0 : fallCnt + 4'd1;
      if (isI2c && (ctrl3[sbg_pkg::BIT_ADDRHOLD] || ctrl3[sbg_pkg::BIT_DATAHOLD])
          && sclFall && fallCnt == 4'd7)
        ackTime <= 1'b1;
      else if (sclRise && fallCnt == 4'd8)
        ackTime <= 1'b0;
      if (holdEvent) releaseBit <= 1'b0;
      else if (wrAcc && wb_adr_i == sbg_pkg::ADDR_STATUS && wb_dat_i[sbg_pkg::ST_RELEASE])
        releaseBit <= 1'b1;
      if (collide) collFlag <= 1'b1;
      else if (wrAcc && wb_adr_i == sbg_pkg::ADDR_STATUS && wb_dat_i[sbg_pkg::ST_COLL])
        collFlag <= 1'b0;
      if (holdEvent
          || (isI2c && stopSeen && ctrl3[sbg_pkg::BIT_STOPIE])
          || (isI2c && startSeen && ctrl3[sbg_pkg::BIT_STARTIE]))
        evtFlag <= 1'b1;
      else if (wrAcc && wb_adr_i == sbg_pkg::ADDR_STATUS && wb_dat_i[sbg_pkg::ST_EVENT])
        evtFlag <= 1'b0;
    end
  end

  // ==========================================================================
  // sda hold timer after each scl fall
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      holdCnt     <= 5'd0;
      sdaHoldDone <= 1'b1;
    end else if (sclFall) begin
      holdCnt <= ctrl3[sbg_pkg::BIT_HOLDSEL] ? 5'(sbg_pkg::HOLD_LONG_CYC)
                                             : 5'(sbg_pkg::HOLD_SHORT_CYC);
      sdaHoldDone <= 1'b0;
    end else if (holdCnt > 5'd1) begin
      holdCnt <= holdCnt - 5'd1;
    end else begin
      holdCnt     <= 5'd0;
      sdaHoldDone <= 1'b1;
    end
  end
endmodule // sbg_top
`default_nettype wire

/* File: verification/sbg_checker.sv */
// Purpose: concurrent checks on the baud generator and hold control ports
// Assumes: a bus write lands on the edge that raises ack; the shadow takes it on the edge that samples ack high
// Notes:   control bits are shadowed from bus writes
`default_nettype none

module sbg_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  mode,
  input wire logic        xferDone,
  input wire logic        rxStrobe,
  input wire logic        rxIsAddr,
  input wire logic        rxAddrMatch,
  input wire logic        startSeen,
  input wire logic        stopSeen,
  input wire logic        sclIn,
  input wire logic        sdaIn,
  input wire logic        sdaDrivingHigh,
  input wire logic        sclOut,
  input wire logic        sclHoldLow,
  input wire logic        sdaHoldDone,
  input wire logic        busIdle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl;
  logic       bufWr;
  logic [3:0] nf;
  logic       sclQ;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // software view
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl   <= 8'h00;
      bufWr <= 1'b0;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == sbg_pkg::ADDR_CTRL3) ctl <= wb_dat_i[7:0];
      if (wb_adr_i == sbg_pkg::ADDR_BUFFER) bufWr <= 1'b1;
    end
  end
  // scl falls since the last start or stop; nine make a byte with its ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclQ <= 1'b1;
      nf   <= 4'h0;
    end else begin
      sclQ <= sclIn;
      if (startSeen || stopSeen) nf <= 4'h0;
      else if (sclQ && !sclIn) nf <= (nf == 4'h8) ? 4'h0 : nf + 4'h1;
    end
  end
  // ==========================================================================
  // properties
  a_idle_clock: assert property (
    !bufWr |-> sclOut) else $error("serial clock moved before any buffer write");
  a_clock_frozen: assert property (
    xferDone |-> ##2 $stable(sclOut)[*8]) else $error("serial clock moved after done");
  a_data_hold: assert property (
    mode == 2'h3 && !rxIsAddr && ctl[sbg_pkg::BIT_DATAHOLD] && $fell(sclIn) && nf == 4'h7
    |-> ##[1:2] sclHoldLow) else $error("no stretch after data byte");
  a_addr_hold: assert property (
    mode == 2'h3 && rxIsAddr && rxAddrMatch && ctl[sbg_pkg::BIT_ADDRHOLD] && $fell(sclIn)
    && nf == 4'h7 |-> ##[1:2] sclHoldLow) else $error("no stretch after address byte");
  a_release_scl: assert property (
    wb_ack_o && wb_we_i && wb_adr_i == sbg_pkg::ADDR_STATUS && wb_dat_i[sbg_pkg::ST_RELEASE]
    |=> ##[0:1] !sclHoldLow) else $error("scl still held after release");
  a_coll_idle: assert property (
    mode == 2'h3 && ctl[sbg_pkg::BIT_COLLDET] && $rose(sclIn) && !sdaIn && sdaDrivingHigh
    |-> ##[0:3] busIdle) else $error("collision did not idle the bus");
  a_hold_short: assert property (
    mode == 2'h3 && !ctl[sbg_pkg::BIT_HOLDSEL] && $fell(sclIn)
    |=> ##1 !sdaHoldDone[*3] ##[1:6] sdaHoldDone) else $error("short sda hold wrong");
  a_hold_long: assert property (
    mode == 2'h3 && ctl[sbg_pkg::BIT_HOLDSEL] && $fell(sclIn)
    |=> ##1 !sdaHoldDone[*8] ##[4:10] sdaHoldDone) else $error("long sda hold wrong");
  c_stretch: cover property ($rose(sclHoldLow));
  c_toggle: cover property ($changed(sclOut));
  c_rx_byte: cover property (mode == 2'h3 && rxStrobe);
  c_collide: cover property (mode == 2'h3 && $rose(sclIn) && !sdaIn && sdaDrivingHigh);
endmodule // sbg_checker

bind sbg_top sbg_checker u_chk (.*);

`default_nettype wire

/* File: verification/sbg_far_model.sv */
// Purpose: far side of the link: pulls scl and sda, drains transmit bytes
// Assumes: open-drain lines with pull-ups, levels synchronous to clk
// Notes:   ready alternates unless stall holds it low, so the fifo always meets a slow consumer
`default_nettype none

module sbg_far_model (
  input  wire logic clk,
  input  wire logic stall,
  input  wire logic sclOut,
  input  wire logic sclHoldLow,
  output logic      sclIn,
  output logic      sdaIn,
  output logic      txReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic farScl = 1'b1;
  logic farSda = 1'b1;
  // wired-and with pull-up: whoever pulls low wins
  assign sclIn = sclOut & farScl & ~sclHoldLow;
  assign sdaIn = farSda;
  always @(posedge clk) txReady <= stall ? 1'b0 : ~txReady;
  task automatic sclTo(input logic v, input int n);
    farScl <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule // sbg_far_model

`default_nettype wire

/* File: verification/tb.sv */
// Purpose: self-checking bench for the baud generator and hold control block
// Assumes: shifter side driven here, far model drains the fifo
// Notes:   reads and tx bytes are checked from queues by a monitor
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, mE, mM;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  rxByte = 8'h0, txByte, a, b, tE;
  logic        xferDone = 1'b0, rxStrobe = 1'b0, rxIsAddr = 1'b0, rxAddrMatch = 1'b0;
  logic        startSeen = 1'b0, stopSeen = 1'b0, sdaDrivingHigh = 1'b0, stall = 1'b1, s;
  logic        wb_ack_o, txValid, txReady, rxAck, sclIn, sdaIn, sclOut, sclHoldLow;
  logic        sdaHoldDone, busIdle;
  logic [31:0] expQ[$], mskQ[$];
  logic [7:0]  txQ[$];
  int          failures = 0, n_compared = 0, n, rl, hc = 0;

  sbg_top u_dut (.*);
  sbg_far_model u_far (.*);

  always #10 clk = ~clk;
  // cycles of scl low before the hold time is reported done
  always @(posedge clk) hc <= sclIn ? 0 : hc + int'(!sdaHoldDone);
  // ==========================================================================
  // monitor
  always @(posedge clk) begin
    if (wb_ack_o && !wb_we_i) begin
      mE = expQ.pop_front();
      mM = mskQ.pop_front();
      `CHK(wb_dat_o & mM, mE)
    end
    if (txValid && txReady) begin
      tE = txQ.pop_front();
      `CHK(txByte, tE)
    end
  end
  // ==========================================================================
  // drivers
  task automatic wb(input logic [3:0] ad, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= ad;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1 && ++k < 100);
    if (k >= 100) failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    wb(ad, 1'b0, 32'h0);
  endtask
  task automatic txw(input logic [7:0] d);
    txQ.push_back(d);
    wb(sbg_pkg::ADDR_BUFFER, 1'b1, {24'h0, d});
  endtask
  task automatic rx(input logic [7:0] d, input logic isA, input logic mt, input logic ak);
    @(posedge clk);
    rxStrobe    <= 1'b1;
    rxByte      <= d;
    rxIsAddr    <= isA;
    rxAddrMatch <= mt;
    @(posedge clk);
    `CHK(rxAck, ak)
    rxStrobe    <= 1'b0;
  endtask
  task automatic span(output int c);
    logic v;
    c = 0;
    v = sclOut;
    do begin
      @(posedge clk);
      c++;
    end while (sclOut === v && c < 300);
  endtask
  task automatic pulse(input logic st);
    startSeen <= !st;
    stopSeen  <= st;
    @(posedge clk);
    startSeen <= 1'b0;
    stopSeen  <= 1'b0;
  endtask
  // start, then eight scl falls; the line is left low after the eighth
  task automatic clk8();
    pulse(1'b0);
    repeat (7) begin
      u_far.sclTo(1'b0, 20);
      u_far.sclTo(1'b1, 20);
    end
    u_far.sclTo(1'b0, 20);
  endtask
  // stop just after a rising serial clock so the line rests high
  task automatic stop_hi();
    @(posedge clk iff sclOut === 1'b0);
    @(posedge clk iff sclOut === 1'b1);
    xferDone <= 1'b1;
    @(posedge clk);
    xferDone <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  // ==========================================================================
  // tests
  initial begin
    void'($urandom(35957));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    rd(sbg_pkg::ADDR_CTRL3, sbg_pkg::CTRL3_RESET, 32'hffffffff);
    a = $urandom;
    wb(sbg_pkg::ADDR_CTRL3, 1'b1, {24'h0, a});
    rd(sbg_pkg::ADDR_CTRL3, {24'h0, a & sbg_pkg::CTRL3_WMASK}, 32'hffffffff);
    wb(4'h2, 1'b1, 32'hffffffff);
    rd(4'h2, 32'h0, 32'hffffffff);
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      mode <= k ? sbg_pkg::MODE_I2C_MASTER : sbg_pkg::MODE_SPI_MASTER;
      rl = 3 + $urandom % 5;
      wb(sbg_pkg::ADDR_RELOAD, 1'b1, rl);
      txw($urandom);
      span(n);
      span(n);
      `CHK(n, 2 * (rl + 1))
      stop_hi();
      repeat (3) @(posedge clk);
      s = sclOut;
      repeat (20) @(posedge clk);
      `CHK(sclOut, s)
    end
    $display("test baud done");
    mode  <= sbg_pkg::MODE_SPI_MASTER;
    stall <= 1'b1;
    for (int i = 0; i < sbg_pkg::FIFO_DEPTH; i++) txw($urandom);
    wb(sbg_pkg::ADDR_BUFFER, 1'b1, 32'h5a);
    stall <= 1'b0;
    n = 0;
    while (txQ.size() != 0 && n++ < 2000) @(posedge clk);
    repeat (4) @(posedge clk);
    `CHK(txValid, 1'b0)
    stop_hi();
    $display("test fifo done");
    mode <= sbg_pkg::MODE_SPI_SLAVE;
    for (int k = 0; k < 2; k++) begin
      wb(sbg_pkg::ADDR_CTRL3, 1'b1, k << sbg_pkg::BIT_OVERWRITE);
      rd(sbg_pkg::ADDR_BUFFER, 32'h0, 32'h0);
      wb(sbg_pkg::ADDR_STATUS, 1'b1, 32'h7);
      a = $urandom;
      b = $urandom;
      rx(a, 1'b0, 1'b0, 1'b0);
      rx(b, 1'b0, 1'b0, 1'b0);
      rd(sbg_pkg::ADDR_BUFFER, k ? b : a, 32'hff);
      rd(sbg_pkg::ADDR_STATUS, 32'h4, 32'h4);
    end
    $display("test overwrite done");
    mode <= sbg_pkg::MODE_I2C_SLAVE;
    for (int k = 0; k < 4; k++) begin
      wb(sbg_pkg::ADDR_CTRL3, 1'b1, (k % 2) << (k / 2 ? 6 : 5));
      wb(sbg_pkg::ADDR_STATUS, 1'b1, 32'h1);
      pulse(k / 2);
      rd(sbg_pkg::ADDR_STATUS, k % 2, 32'h1);
    end
    $display("test events done");
    for (int k = 0; k < 2; k++) begin
      wb(sbg_pkg::ADDR_CTRL3, 1'b1, k ? 32'h2 : 32'h1);
      wb(sbg_pkg::ADDR_STATUS, 1'b1, 32'h7);
      rd(sbg_pkg::ADDR_BUFFER, 32'h0, 32'h0);
      a = $urandom;
      rx(a, k, k, 1'b1);
      clk8();
      u_far.sclTo(1'b1, 2);
      `CHK(sclIn, 1'b0)
      rd(sbg_pkg::ADDR_BUFFER, a, 32'hff);
      wb(sbg_pkg::ADDR_STATUS, 1'b1, 32'h10);
      @(posedge clk);
      `CHK(sclHoldLow, 1'b0)
    end
    $display("test hold done");
    for (int h = 0; h < 2; h++) begin
      wb(sbg_pkg::ADDR_CTRL3, 1'b1, (h << sbg_pkg::BIT_HOLDSEL) | 32'h1);
      clk8();
      n = h ? sbg_pkg::HOLD_LONG_CYC : sbg_pkg::HOLD_SHORT_CYC;
      `CHK(hc >= n && hc <= n + 3, 1'b1)
      rd(sbg_pkg::ADDR_CTRL3, 32'h80, 32'h80);
      wb(sbg_pkg::ADDR_STATUS, 1'b1, 32'h10);
      u_far.sclTo(1'b1, 20);
      u_far.sclTo(1'b0, 20);
      u_far.sclTo(1'b1, 20);
      rd(sbg_pkg::ADDR_CTRL3, 32'h0, 32'h80);
    end
    $display("test ack time done");
    wb(sbg_pkg::ADDR_CTRL3, 1'b1, 32'h4);
    wb(sbg_pkg::ADDR_STATUS, 1'b1, 32'h7);
    sdaDrivingHigh <= 1'b1;
    u_far.farSda   <= 1'b0;
    u_far.sclTo(1'b0, 20);
    u_far.sclTo(1'b1, 20);
    rd(sbg_pkg::ADDR_STATUS, 32'h2, 32'h2);
    `CHK(busIdle, 1'b1)
    sdaDrivingHigh <= 1'b0;
    u_far.farSda   <= 1'b1;
    $display("test collision done");
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire
